// *** hdl/bank_select_base_decode.sv ***
// Host window decode: base compare, bank pointer and routing into the banks
`timescale 1ns/10ps
`default_nettype none
`include "bank_window_defines.svh"
module bank_select_base_decode
  import bank_window_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host bus, synchronous to clk
  input wire logic [15:0] host_addr,
  input wire logic [3:0] host_be,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  output logic host_ready,
  output logic host_hit,
  output logic host_ack,
  output logic [31:0] host_rdata,
  // Configuration ROM strap and word read
  input wire logic config_rom_present_pin,
  output logic rom_req,
  output logic [7:0] rom_word,
  input wire logic rom_ack,
  input wire logic [15:0] rom_data,
  // Live decode state
  output logic [5:0] bank_sel,
  output logic [15:0] base_addr,
  // Forwarded access into the selected bank
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_bank,
  output logic [3:0] reg_offset,
  output logic [3:0] reg_be,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);

  window_s s;
  window_s next_s;

  logic rom_present;
  logic rom_present_settled;
  logic load;
  logic [15:0] load_data;
  logic load_done;

  // Strap pin crosses in from outside the clock domain
  pin_sync3 u_strap_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(config_rom_present_pin),
    .level(rom_present),
    .settled(rom_present_settled)
  );

  // One-time base fetch after reset
  base_loader u_base_loader (
    .clk(clk),
    .rst_n(rst_n),
    .rom_present(rom_present),
    .rom_present_settled(rom_present_settled),
    .rom_req(rom_req),
    .rom_word(rom_word),
    .rom_ack(rom_ack),
    .rom_data(rom_data),
    .load(load),
    .load_data(load_data),
    .done(load_done)
  );

  // Host cycles are refused until the base address is final; a fetched base lands one edge after the load pulse
  assign host_ready = load_done && !load;

  // Claim only on a full base match of both fields
  assign host_hit = host_ready && (host_wr || host_rd) && base_match(host_addr, s.base); // [RULE_09] [RULE_10] [RULE_13]

  // Local lanes, data and write selects for the addressed word group
  logic [1:0] grp;
  logic in_bank0;
  logic [3:0] local_be;
  logic [31:0] local_rdata;
  logic [3:0] wr_be;
  logic bad_be;

  always_comb begin
    grp = host_addr[3:2];
    in_bank0 = (s.bank == `BANK_ZERO);
    local_be = 4'b0000;
    local_rdata = 32'h0000_0000;
    case (grp)
      `GRP_BASE: begin
        if (in_bank0) begin
          local_be = 4'b0011;
          local_rdata = {16'h0000, s.base};
        end
      end
      `GRP_BUS_ERR: begin
        if (in_bank0) begin
          local_be = 4'b1100;
          local_rdata = {s.err_flag, s.err_val, 11'h000, 16'h0000};
        end
      end
      `GRP_BANK: begin
        // Whole group stays local in every bank; 0xC/0xD read as reserved
        local_be = 4'b1111; // [RULE_03] [RULE_05]
        local_rdata = {10'h000, s.bank, 16'h0000}; // [RULE_02] [RULE_04]
      end
      default: begin
        local_be = 4'b0000;
      end
    endcase
    wr_be = (host_hit && host_wr) ? host_be : 4'b0000;
    bad_be = host_hit && !be_legal(host_be);
  end

  // Next state: local registers, forwarding stage and answer stage
  always_comb begin
    next_s = s;
    next_s.fwd_wr = 1'b0;
    next_s.fwd_rd = 1'b0;
    next_s.pend = host_hit;

    // Answer stage: merge local data with what the bank returned
    next_s.ack = s.pend;
    if (s.pend) begin
      next_s.rdata = s.pend_local | (reg_rdata & lane_mask(s.pend_mask));
    end

    // Forward stage: lanes not held here go to the selected bank
    if (host_hit) begin
      next_s.fwd_bank = s.bank; // [RULE_01] [RULE_13]
      next_s.fwd_ofs = host_addr[3:0]; // [RULE_13]
      next_s.fwd_be = host_be & ~local_be;
      next_s.fwd_wdata = host_wdata;
      next_s.fwd_wr = host_wr && ((host_be & ~local_be) != 4'b0000);
      next_s.fwd_rd = host_rd && ((host_be & ~local_be) != 4'b0000);
      next_s.pend_local = host_rd ? (local_rdata & lane_mask(host_be & local_be)) : 32'h0000_0000;
      next_s.pend_mask = host_rd ? (host_be & ~local_be) : 4'b0000;
    end

    // Bank pointer: byte lane 2 of group 3, reached at 0xC or 0xE
    if (grp == `GRP_BANK && wr_be[2]) begin
      next_s.bank = host_wdata[21:16]; // [RULE_02] [RULE_03] [RULE_04] [RULE_05]
    end

    // Base address: host writes change only the live decode value
    if (grp == `GRP_BASE && in_bank0) begin
      if (wr_be[0]) begin
        next_s.base[`BASE_LO_MSB:`BASE_LO_LSB] = host_wdata[7:5]; // [RULE_08] [RULE_10]
      end
      if (wr_be[1]) begin
        next_s.base[`BASE_HI_MSB:`BASE_HI_LSB] = host_wdata[15:8]; // [RULE_08] [RULE_09]
      end
    end

    // ROM fetch result replaces the reset base once
    if (load) begin
      next_s.base = load_data; // [RULE_06]
    end

    // Bus error flag: write one clears, a new error in the same cycle wins
    if (grp == `GRP_BUS_ERR && in_bank0 && wr_be[3] && host_wdata[`BUS_ERR_FLAG_BIT]) begin
      next_s.err_flag = 1'b0; // [RULE_11]
    end
    if (bad_be) begin
      next_s.err_flag = 1'b1;
      next_s.err_val = host_be;
    end
  end

  // State register; base resets to the default used when no ROM is fitted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.base <= `BASE_RESET; // [RULE_07]
      s.bank <= `BANK_PTR_RESET; // [RULE_02]
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign host_ack = s.ack;
  assign host_rdata = s.rdata;
  assign bank_sel = s.bank;
  assign base_addr = s.base;
  assign reg_wr = s.fwd_wr;
  assign reg_rd = s.fwd_rd;
  assign reg_bank = s.fwd_bank;
  assign reg_offset = s.fwd_ofs;
  assign reg_be = s.fwd_be;
  assign reg_wdata = s.fwd_wdata;

endmodule
`default_nettype wire

// *** hdl/bank_window_defines.svh ***
// Offsets, field positions, reset values and the bank count for the bank window
//
// Notes on behaviour
// RULE_01: Sixty-four banks, pointer picks the responding bank.
// RULE_02: Pointer is bits 5..0, read/write, resets zero.
// RULE_03: Bank choice register answers in every bank.
// RULE_04: Reached as dword at 0xC, word/byte 0xE.
// RULE_05: Dword write at 0xC leaves 0xC/0xD alone.
// RULE_06: ROM present: base loads from ROM word 0.
// RULE_07: ROM absent: base resets to 0x300.
// RULE_08: Host base writes never reach the ROM.
// RULE_09: Base bits 15..8 compared with address 15..8.
// RULE_10: Base bits 7..5 compared; bits 4..0 reserved.
// RULE_11: Write-one-to-clear bits clear on one only.
// RULE_12: Host writes reserved bits back unchanged.
// RULE_13: Claim on full match, route by window offset.
`ifndef BANK_WINDOW_DEFINES_SVH
`define BANK_WINDOW_DEFINES_SVH

// Window offsets within a bank (byte addresses)
`define BASE_OFS 4'h0
`define BUS_ERR_OFS 4'h6
`define BANK_DW_OFS 4'hC
`define BANK_OFS 4'hE

// Word groups of the window, offset bits 3..2
`define GRP_BASE 2'h0
`define GRP_BUS_ERR 2'h1
`define GRP_BANK 2'h3

// Bank pointer field
`define BANK_PTR_W 6
`define BANK_COUNT 64
`define BANK_PTR_RESET 6'h00
`define BANK_ZERO 6'h00

// Base address fields
`define BASE_RESET 16'h0300
`define BASE_MASK 16'hFFE0
`define BASE_HI_MSB 15
`define BASE_HI_LSB 8
`define BASE_LO_MSB 7
`define BASE_LO_LSB 5

// Bus error status fields, within the upper half of word group 1
`define BUS_ERR_FLAG_BIT 31
`define BUS_ERR_VAL_MSB 30
`define BUS_ERR_VAL_LSB 27

// Configuration ROM word that holds the base address
`define ROM_BASE_WORD 8'h00
`endif

// *** hdl/bank_window_pkg.sv ***
// Types and shared helper functions for the bank window
package bank_window_pkg;

  typedef logic [5:0] bank_ptr_t;

  // Base loader states, Gray coded along wait, fetch, done
  typedef enum logic [1:0] {
    LOAD_WAIT = 2'b00,
    LOAD_FETCH = 2'b01,
    LOAD_DONE = 2'b11
  } load_state_e;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
    logic settled;
    logic [1:0] fill;
  } sync_s;

  typedef struct packed {
    load_state_e state;
    logic load;
    logic [15:0] data;
  } loader_s;

  typedef struct packed {
    logic [15:0] base;
    bank_ptr_t bank;
    logic err_flag;
    logic [3:0] err_val;
    logic pend;
    logic [31:0] pend_local;
    logic [3:0] pend_mask;
    logic fwd_wr;
    logic fwd_rd;
    bank_ptr_t fwd_bank;
    logic [3:0] fwd_ofs;
    logic [3:0] fwd_be;
    logic [31:0] fwd_wdata;
    logic ack;
    logic [31:0] rdata;
  } window_s;

  // Address hits the window when both base fields match
  function automatic logic base_match(input logic [15:0] addr, input logic [15:0] base);
    base_match = (addr[15:8] == base[15:8]) && (addr[7:5] == base[7:5]);
  endfunction

  // Byte enable patterns a byte, word or dword access may carry
  function automatic logic be_legal(input logic [3:0] be);
    case (be)
      4'b0001, 4'b0010, 4'b0100, 4'b1000: be_legal = 1'b1;
      4'b0011, 4'b1100, 4'b1111: be_legal = 1'b1;
      default: be_legal = 1'b0;
    endcase
  endfunction

  // Expand byte enables to a bit mask over 32 data bits
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage

// *** hdl/base_loader.sv ***
// Fetches the base address from the configuration ROM once after reset
`timescale 1ns/10ps
`default_nettype none
`include "bank_window_defines.svh"
module base_loader
  import bank_window_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strap level after synchronising
  input wire logic rom_present,
  input wire logic rom_present_settled,
  // Configuration ROM word read
  output logic rom_req,
  output logic [7:0] rom_word,
  input wire logic rom_ack,
  input wire logic [15:0] rom_data,
  // Result toward the window
  output logic load,
  output logic [15:0] load_data,
  output logic done
);

  loader_s s;
  loader_s next_s;

  // Strap is judged once settled; absent ROM keeps the reset base
  always_comb begin
    next_s = s;
    next_s.load = 1'b0;
    case (s.state)
      LOAD_WAIT: begin
        if (rom_present_settled) begin
          next_s.state = rom_present ? LOAD_FETCH : LOAD_DONE; // [RULE_06] [RULE_07]
        end
      end
      LOAD_FETCH: begin
        if (rom_ack) begin
          next_s.data = rom_data & `BASE_MASK; // [RULE_06] [RULE_10]
          next_s.load = 1'b1;
          next_s.state = LOAD_DONE;
        end
      end
      LOAD_DONE: begin
        next_s.state = LOAD_DONE;
      end
      default: begin
        next_s.state = LOAD_WAIT;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{state: LOAD_WAIT, load: 1'b0, data: 16'h0000};
    end else begin
      s <= next_s;
    end
  end

  assign rom_req = (s.state == LOAD_FETCH);
  assign rom_word = `ROM_BASE_WORD;
  assign load = s.load;
  assign load_data = s.data;
  assign done = (s.state == LOAD_DONE);

endmodule
`default_nettype wire

// *** hdl/pin_sync3.sv ***
// Three-stage synchroniser for a level pin, with an agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync3
  import bank_window_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and filtered level
  input wire logic pin,
  output logic level,
  output logic settled
);

  sync_s s;
  sync_s next_s;

  // Level follows the pin only once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.ff1 = pin;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    // Count the first three edges so the reset zeros never pass as a settled level
    if (s.fill != 2'h3) begin
      next_s.fill = s.fill + 2'h1;
    end
    if (s.fill == 2'h3 && s.ff2 == s.ff3) begin
      next_s.level = s.ff3;
      next_s.settled = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign settled = s.settled;

endmodule
`default_nettype wire

// *** testbench/bank_window_properties.sv ***
// Concurrent checks on the bank window decode ports
`timescale 1ns/10ps
`default_nettype none
module bank_window_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host bus
  input wire logic [15:0] host_addr,
  input wire logic [3:0] host_be,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  input wire logic host_ready,
  input wire logic host_hit,
  input wire logic host_ack,
  // ROM, decode state and forwarding
  input wire logic rom_req,
  input wire logic rom_ack,
  input wire logic [15:0] rom_data,
  input wire logic [5:0] bank_sel,
  input wire logic [15:0] base_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_bank
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic grp3;
  logic [15:0] rom_seen;

  // Access into word group three, where the bank pointer lives
  assign grp3 = host_hit && host_addr[3:2] == 2'h3;

  // Keep the ROM word taken with the ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_seen <= 16'h0000;
    end else if (rom_req && rom_ack) begin
      rom_seen <= rom_data;
    end
  end

  // Decode, answer and bank pointer relations
  AST_HIT_EQ: assert property (host_hit == (host_ready && (host_wr || host_rd)
    && host_addr[15:5] == base_addr[15:5]))
    else $error("hit does not follow base compare");
  AST_ACK_AFTER: assert property (host_hit |-> ##2 host_ack)
    else $error("no ack two cycles after hit");
  AST_ACK_CAUSE: assert property (host_ack |-> $past(host_hit, 2))
    else $error("ack without hit");
  AST_BANK_WRITE: assert property (grp3 && host_wr && host_be[2]
    && (host_be == 4'hF || host_be[1:0] == 2'h0) |=> bank_sel == $past(host_wdata[21:16]))
    else $error("bank pointer not written");
  AST_BANK_HOLD: assert property (!(grp3 && host_wr) |=> $stable(bank_sel))
    else $error("bank pointer changed");
  AST_GRP3_LOCAL: assert property (grp3 |=> !reg_wr && !reg_rd)
    else $error("group three forwarded");
  AST_FWD_BANK: assert property ((reg_wr || reg_rd) |-> reg_bank == bank_sel && $past(host_hit))
    else $error("forward to wrong bank");
  AST_ROM_LOAD: assert property (rom_req && rom_ack |-> ##[1:2] base_addr == (rom_seen & 16'hFFE0))
    else $error("base not loaded from ROM");
  AST_BASE_RSVD: assert property (base_addr[4:0] == 5'h00)
    else $error("base reserved bits set");
  AST_ROM_QUIET: assert property (host_hit |-> !rom_req)
    else $error("ROM busy during host access");
endmodule

bind bank_select_base_decode bank_window_properties chk (.clk(clk), .rst_n(rst_n), .host_addr(host_addr),
  .host_be(host_be), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_ready(host_ready),
  .host_hit(host_hit), .host_ack(host_ack), .rom_req(rom_req), .rom_ack(rom_ack), .rom_data(rom_data),
  .bank_sel(bank_sel), .base_addr(base_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bank(reg_bank));
`default_nettype wire

// *** testbench/rom_bank_model.sv ***
// Configuration ROM reader and bank register responder
`timescale 1ns/10ps
`default_nettype none
module rom_bank_model #(
  parameter logic [15:0] ROM_WORD0 = 16'h4A5F,
  parameter int ACK_DLY = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ROM word read
  input wire logic rom_req,
  output logic rom_ack,
  output logic [15:0] rom_data,
  // Forwarded bank read
  input wire logic reg_rd,
  input wire logic [5:0] reg_bank,
  input wire logic [3:0] reg_offset,
  input wire logic [3:0] reg_be,
  output logic [31:0] reg_rdata
);
  int cnt;

  // Count the wait of a fetch, ack after a fixed delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
    end else begin
      cnt <= (rom_req && !rom_ack) ? cnt + 1 : 0;
    end
  end

  // Data valid only with the ack, churns otherwise
  assign rom_ack = rom_req && cnt == ACK_DLY;
  assign rom_data = rom_ack ? ROM_WORD0 : ~ROM_WORD0 ^ 16'(cnt);
  assign reg_rdata = {32{!reg_rd}} ^ {8'h5A, 2'h0, reg_bank, reg_offset, reg_be, 8'hA5};
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the bank window decode
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [15:0] ROM_W = 16'h4A5F;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b0;
  logic ready, hit, ack, rom_req, rom_ack, reg_wr, reg_rd, fwd;
  logic [15:0] addr = 16'h0000, base = 16'h0300, base_addr, rom_data;
  logic [3:0] be = 4'h0, reg_offset, reg_be;
  logic [31:0] wdata = 32'h0000_0000, rdata, reg_wdata, reg_rdata, got, d, fw;
  logic [5:0] bank_sel, reg_bank, n;
  logic [7:0] rom_word;
  logic [3:0] ofs_t [3] = '{4'hC, 4'hE, 4'hE};
  logic [3:0] be_t [3] = '{4'hF, 4'hC, 4'h4};
  int mismatches = 0, comparisons = 0, i, k;

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  bank_select_base_decode dut (.clk(clk), .rst_n(rst_n), .host_addr(addr), .host_be(be), .host_wr(wr),
    .host_rd(rd), .host_wdata(wdata), .host_ready(ready), .host_hit(hit), .host_ack(ack), .host_rdata(rdata),
    .config_rom_present_pin(pin), .rom_req(rom_req), .rom_word(rom_word), .rom_ack(rom_ack),
    .rom_data(rom_data), .bank_sel(bank_sel), .base_addr(base_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_bank(reg_bank), .reg_offset(reg_offset), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  rom_bank_model #(.ROM_WORD0(ROM_W)) model (.clk(clk), .rst_n(rst_n), .rom_req(rom_req), .rom_ack(rom_ack),
    .rom_data(rom_data), .reg_rd(reg_rd), .reg_bank(reg_bank), .reg_offset(reg_offset), .reg_be(reg_be),
    .reg_rdata(reg_rdata));

  // Window address at the current base
  function automatic logic [15:0] wa(input logic [3:0] ofs);
    wa = {base[15:5], 1'b0, ofs};
  endfunction

  // Expected read of the bank pointer group
  function automatic logic [31:0] grp3(input logic [3:0] b, input logic [5:0] v);
    grp3 = {10'h0, v, 16'h0} & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One host cycle, then the ack two cycles on
  task automatic access(input logic [15:0] a, input logic [3:0] b, input logic w, input logic [31:0] dw,
                        input logic take);
    addr = a;
    be = b;
    wr = w;
    rd = !w;
    wdata = dw;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    fwd = reg_wr | reg_rd;
    fw = reg_wdata & {32{reg_wr}};
    @(negedge clk);
    got = rdata;
    check({31'h0, ack}, {31'h0, take});
  endtask

  task automatic boot(input logic p);
    rst_n = 1'b0;
    pin = p;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 40 && ready !== 1'b1; k++) @(negedge clk);
    check({31'h0, ready}, 32'h1);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'he6be4a42));
    boot(1'b0);
    check({16'h0, base_addr}, 32'h0000_0300);
    check({26'h0, bank_sel}, 32'h0);
    $display("reset test done");
    for (i = 0; i < 24; i++) begin
      k = $urandom_range(2);
      n = (i == 0) ? 6'h3F : 6'($urandom);
      d = $urandom;
      d[21:16] = n;
      access(wa(ofs_t[k]), be_t[k], 1'b1, d, 1'b1);
      check({26'h0, bank_sel}, {26'h0, n});
      check({31'h0, fwd}, 32'h0);
      k = $urandom_range(2);
      access(wa(ofs_t[k]), be_t[k], 1'b0, 32'h0, 1'b1);
      check(got, grp3(be_t[k], n));
    end
    n = 6'($urandom_range(63, 1));
    access(wa(4'hE), 4'hC, 1'b1, {10'h0, n, 16'h0}, 1'b1);
    access(wa(4'h8), 4'hF, 1'b0, 32'h0, 1'b1);
    check({31'h0, fwd}, 32'h1);
    check(got, {8'h5A, 2'h0, n, 4'h8, 4'hF, 8'hA5});
    d = $urandom | 32'h0000_0001;
    access(wa(4'h4), 4'hF, 1'b1, d, 1'b1);
    check({31'h0, fwd}, 32'h1);
    check(fw, d);
    for (i = 5; i < 16; i++) access(wa(4'h8) ^ (16'h1 << i), 4'hF, 1'b0, 32'h0, 1'b0);
    $display("bank test done");
    access(wa(4'hE), 4'h4, 1'b1, 32'h0, 1'b1);
    access(wa(4'h0), 4'h3, 1'b0, 32'h0, 1'b1);
    check({16'h0, got[15:0]}, {16'h0, base});
    d = $urandom;
    access(wa(4'h0), 4'h3, 1'b1, {16'h0, d[15:5], got[4:0]}, 1'b1);
    base = {d[15:5], 5'h00};
    check({16'h0, base_addr}, {16'h0, base});
    check({31'h0, rom_req}, 32'h0);
    access(wa(4'h8), 4'b0101, 1'b0, 32'h0, 1'b1);
    for (i = 0; i < 3; i++) begin
      access(wa(4'h6), 4'hC, 1'b0, 32'h0, 1'b1);
      check({31'h0, got[31]}, (i < 2) ? 32'h1 : 32'h0);
      if (i == 0) check({28'h0, got[30:27]}, 32'h5);
      access(wa(4'h6), 4'hC, 1'b1, {i[0], 31'h0}, 1'b1);
    end
    $display("base test done");
    boot(1'b1);
    base = ROM_W & 16'hFFE0;
    check({16'h0, base_addr}, {16'h0, base});
    check({24'h0, rom_word}, 32'h0);
    access(wa(4'hC), 4'hF, 1'b0, 32'h0, 1'b1);
    check(got, 32'h0);
    $display("rom test done");
    end_sim;
  end

  // Watchdog against a hung handshake
  initial begin
    #10us;
    mismatches++;
    end_sim;
  end
endmodule
`default_nettype wire
